/* File: verilog/anab_regs.sv */
// local advertisement and link partner ability registers
// Notes on behaviour
// - local bit 15 next page, read/write, resets to zero.
// - local bit 10 pause, read/write, one offers full-duplex pause.
// - pause reset value is taken from its strap pin after reset.
// - technology bits 8..5 load from led config pins after reset, stay writable.
// - bit 8 100TX full, 7 100TX, 6 10T full, 5 10T.
// - 100BASE-T4 bit 9 writable, resets zero, only advertised.
// - local bit 11 asymmetric pause, read/write, resets zero.
// - selector resets to 00001; 00001 802.3, 00010 802.9, 00000/11111 reserved.
// - partner register is read-only, no reset value; bit 15 partner next page.
// - partner bit 14 shows partner acknowledged our code word.
// - partner bits 10 and 11 show pause and asymmetric pause.
// - partner bits 8..5 show technologies with the local mapping.
// - partner bit 9 shows partner 100BASE-T4 ability.
// - partner bits 4..0 show partner selector, same encoding.
// - new base page loads partner register, sets flag cleared on read.
`timescale 1ns/1ps
`default_nettype none

module anab_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// configuration straps from pins
	input wire logic pause_cfg_pin,
	input wire logic [3:0] led_config_pins,
	// management access
	input wire anab_pkg::anab_req_t mgmt_req,
	output logic [15:0] mgmt_rdata,
	// received base page from the negotiation logic
	input wire logic page_rx_valid,
	input wire logic [15:0] page_rx_word,
	// state toward the negotiation logic
	output logic [15:0] local_adv_word,
	output logic page_rcvd
);

	logic [anab_pkg::STRAP_W-1:0] strap_meta_q;
	logic [anab_pkg::STRAP_W-1:0] strap_sync_q;
	logic strap_done_q;
	logic [15:0] local_q;
	logic [15:0] local_d;
	logic [15:0] partner_q;
	logic page_rcvd_q;
	logic page_rcvd_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [15:0] strap_word;

	wire hit_local = mgmt_req.addr == anab_pkg::ADDR_LOCAL_ADV;
	wire hit_partner = mgmt_req.addr == anab_pkg::ADDR_PARTNER;
	wire hit_exp = mgmt_req.addr == anab_pkg::ADDR_EXPANSION;
	wire wr_local = mgmt_req.wr && hit_local;
	wire rd_exp = mgmt_req.rd && hit_exp;
	wire [15:0] partner_view = partner_q & anab_pkg::PARTNER_RD_MASK;
	wire [15:0] exp_view = {14'h0000, page_rcvd_q, 1'b0};

	// two-flop synchroniser for straps, straps are static levels
	always_ff @(posedge core_clk) begin
		strap_meta_q <= {pause_cfg_pin, led_config_pins};
		strap_sync_q <= strap_meta_q;
	end

	// reset value overlaid with straps
	always_comb begin
		strap_word = anab_pkg::LOCAL_RESET;
		strap_word[anab_pkg::BIT_PAUSE] = strap_sync_q[4];
		strap_word[anab_pkg::BIT_TECH_HI:anab_pkg::BIT_TECH_LO] = strap_sync_q[3:0];
	end

	// local word: strap load once after reset, then software writes
	always_comb begin
		local_d = local_q;
		if (!strap_done_q) begin
			local_d = strap_word;
		end else if (wr_local) begin
			local_d = mgmt_req.wdata & anab_pkg::LOCAL_WR_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			local_q <= anab_pkg::LOCAL_RESET;
			strap_done_q <= 1'b0;
		end else begin
			local_q <= local_d;
			strap_done_q <= 1'b1;
		end
	end

	// partner register holds the received word, no reset value
	always_ff @(posedge core_clk) begin
		if (page_rx_valid) begin
			partner_q <= page_rx_word;
		end
	end

	// page received: set wins over clear on read
	always_comb begin
		page_rcvd_d = page_rcvd_q;
		if (rd_exp) begin
			page_rcvd_d = 1'b0;
		end
		if (page_rx_valid) begin
			page_rcvd_d = 1'b1;
		end
	end

	// read data mux, unmapped numbers read zero
	always_comb begin
		rdata_d = 16'h0000;
		if (mgmt_req.rd && hit_local) begin
			rdata_d = local_q;
		end else if (mgmt_req.rd && hit_partner) begin
			rdata_d = partner_view;
		end else if (rd_exp) begin
			rdata_d = exp_view;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			page_rcvd_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			page_rcvd_q <= page_rcvd_d;
			rdata_q <= rdata_d;
		end
	end

	assign mgmt_rdata = rdata_q;
	assign local_adv_word = local_q;
	assign page_rcvd = page_rcvd_q;

	// checks
	AST_NP_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local |=> local_q[15] == $past(mgmt_req.wdata[15]))
		else $error("next page bit did not take written value");

	AST_PAUSE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local |=> local_q[10] == $past(mgmt_req.wdata[10]))
		else $error("pause bit did not take written value");

	AST_PAUSE_STRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> local_q[10] == $past(strap_sync_q[4]))
		else $error("pause strap not loaded");

	AST_TECH_STRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> local_q[8:5] == $past(strap_sync_q[3:0]))
		else $error("technology straps not loaded");

	AST_T4_ASYM: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local
		|=> local_q[9] == $past(mgmt_req.wdata[9]) && local_q[11] == $past(mgmt_req.wdata[11]))
		else $error("t4 or asymmetric pause bit wrong after write");

	AST_SEL_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rst_n) |-> local_q[4:0] == anab_pkg::SEL_IEEE_8023 && local_q[15] == 1'b0)
		else $error("selector or next page reset value wrong");

	AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q |-> local_q[14] == 1'b0 && local_q[12] == 1'b0)
		else $error("reserved local bit set");

	AST_PARTNER_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid ##1 (mgmt_req.rd && hit_partner && !page_rx_valid)
		|=> mgmt_rdata == ($past(page_rx_word, 2) & anab_pkg::PARTNER_RD_MASK))
		else $error("partner read does not show received word");

	AST_PAGE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> page_rcvd_q ##1 (page_rcvd_q || $past(rd_exp)))
		else $error("page received flag not set or lost");

	AST_PAGE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_exp && !page_rx_valid |=> !page_rcvd_q && mgmt_rdata[1] == $past(page_rcvd_q))
		else $error("page received flag not cleared on read");

	// local word checks
	AST_ASYM_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rst_n) |-> local_q[anab_pkg::BIT_ASYM_PAUSE] == 1'b0)
		else $error("asymmetric pause bit not zero after reset");

	AST_T4_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rst_n) |-> local_q[anab_pkg::BIT_T4] == 1'b0)
		else $error("t4 bit not zero after reset");

	AST_LOCAL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && !wr_local |=> local_q == $past(local_q))
		else $error("local word changed without a write");

	AST_STRAP_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q |=> strap_done_q)
		else $error("strap load repeated outside reset");

	AST_STRAP_DONE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> strap_done_q)
		else $error("strap load not finished after one cycle");

	AST_SEL_STRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> local_q[anab_pkg::BIT_SEL_HI:0] == anab_pkg::SEL_IEEE_8023)
		else $error("selector wrong after strap load");

	AST_NP_STRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> local_q[15] == 1'b0 && local_q[11] == 1'b0 && local_q[9] == 1'b0)
		else $error("next page, asymmetric pause or t4 set after strap load");

	AST_TECH_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local |=> local_q[8:5] == $past(mgmt_req.wdata[8:5]))
		else $error("technology bits did not take written value");

	AST_SEL_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local
		|=> local_q[anab_pkg::BIT_SEL_HI:0] == $past(mgmt_req.wdata[anab_pkg::BIT_SEL_HI:0]))
		else $error("selector did not take written value");

	AST_RSVD_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && wr_local |=> local_q[14] == 1'b0 && local_q[12] == 1'b0)
		else $error("reserved local bit taken from write");

	AST_STRAP_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_q |=> local_q[14] == 1'b0 && local_q[12] == 1'b0)
		else $error("reserved local bit set by strap load");

	AST_NO_WRITE_OTHER: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && mgmt_req.wr && !hit_local |=> local_q == $past(local_q))
		else $error("write to another register changed local word");

	// partner word checks
	AST_PARTNER_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_q == $past(page_rx_word))
		else $error("partner word not loaded from page");

	AST_PARTNER_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid ##1 !page_rx_valid |=> partner_q == $past(page_rx_word, 2))
		else $error("partner word changed without a page");

	AST_PARTNER_NP: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[anab_pkg::BIT_NEXT_PAGE] == $past(page_rx_word[15]))
		else $error("partner next page bit wrong");

	AST_PARTNER_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[anab_pkg::BIT_ACK] == $past(page_rx_word[14]))
		else $error("partner acknowledge bit wrong");

	AST_PARTNER_PAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[11:10] == $past(page_rx_word[11:10]))
		else $error("partner pause bits wrong");

	AST_PARTNER_TECH: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[8:5] == $past(page_rx_word[8:5]))
		else $error("partner technology bits wrong");

	AST_PARTNER_T4: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[anab_pkg::BIT_T4] == $past(page_rx_word[9]))
		else $error("partner t4 bit wrong");

	AST_PARTNER_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rx_valid |=> partner_view[4:0] == $past(page_rx_word[4:0]))
		else $error("partner selector wrong");

	AST_PARTNER_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
		mgmt_req.rd && hit_partner |=> mgmt_rdata[12] == 1'b0)
		else $error("reserved partner bit read as one");

	// read port and flag checks
	AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mgmt_req.rd |=> mgmt_rdata == 16'h0000)
		else $error("read data not zero without a read");

	AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
		mgmt_req.rd && !hit_local && !hit_partner && !hit_exp |=> mgmt_rdata == 16'h0000)
		else $error("unmapped read not zero");

	AST_LOCAL_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
		mgmt_req.rd && hit_local |=> mgmt_rdata == $past(local_q))
		else $error("local read does not show local word");

	AST_LOCAL_RD_WR: assert property (@(posedge core_clk) disable iff (!rst_n)
		mgmt_req.rd && wr_local |=> mgmt_rdata == $past(local_q))
		else $error("read with write did not return old local word");

	AST_EXP_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_exp |=> mgmt_rdata[15:2] == 14'h0000 && mgmt_rdata[0] == 1'b0)
		else $error("flag register shows bits other than the flag");

	AST_EXP_READ_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_exp |=> mgmt_rdata[anab_pkg::BIT_PAGE_RCVD] == $past(page_rcvd_q))
		else $error("flag read does not show flag");

	AST_PAGE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		page_rcvd_q && !rd_exp |=> page_rcvd_q)
		else $error("page flag lost without a read");

	AST_PAGE_STAY_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		!page_rcvd_q && !page_rx_valid |=> !page_rcvd_q)
		else $error("page flag set without a page");

	AST_PAGE_SET_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_exp && page_rx_valid |=> page_rcvd_q)
		else $error("clear on read beat a new page");

	AST_PAGE_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rst_n) |-> !page_rcvd_q && mgmt_rdata == 16'h0000)
		else $error("flag or read data not clear after reset");

endmodule

`default_nettype wire

/* File: verilog/anab_pkg.sv */
// shared constants and types for the auto-negotiation ability registers
package anab_pkg;

	// register numbers on the management port
	localparam logic [4:0] ADDR_LOCAL_ADV = 5'h04;
	localparam logic [4:0] ADDR_PARTNER = 5'h05;
	localparam logic [4:0] ADDR_EXPANSION = 5'h06;

	// field positions
	localparam int BIT_NEXT_PAGE = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_REMOTE_FAULT = 13;
	localparam int BIT_ASYM_PAUSE = 11;
	localparam int BIT_PAUSE = 10;
	localparam int BIT_T4 = 9;
	localparam int BIT_TECH_LO = 5;
	localparam int BIT_TECH_HI = 8;
	localparam int BIT_SEL_HI = 4;
	localparam int BIT_PAGE_RCVD = 1;

	// writable and readable bits
	localparam logic [15:0] LOCAL_WR_MASK = 16'hAFFF;
	localparam logic [15:0] PARTNER_RD_MASK = 16'hEFFF;

	// selector codes
	localparam logic [4:0] SEL_IEEE_8023 = 5'h01;
	localparam logic [4:0] SEL_IEEE_8029 = 5'h02;
	localparam logic [4:0] SEL_RSVD_LO = 5'h00;
	localparam logic [4:0] SEL_RSVD_HI = 5'h1F;

	// reset value of the local word, straps overlay pause and technology bits
	localparam logic [15:0] LOCAL_RESET = 16'h0001;

	// strap count: one pause strap plus four technology straps
	localparam int STRAP_W = 5;

	// one management register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} anab_req_t;

endpackage

/* File: verif/anab_partner_model.sv */
// link partner model handing base pages to the block
`timescale 1ns/1ps
`default_nettype none
module anab_partner_model (
	// clock
	input wire logic core_clk,
	// received page toward the block
	output logic page_rx_valid,
	output logic [15:0] page_rx_word
);
	initial begin
		page_rx_valid = 1'h0;
		page_rx_word = 16'h0000;
	end
	// one base page for one cycle, then the word no longer holds
	task send_page(input logic [15:0] w);
		page_rx_valid = 1'h1;
		page_rx_word = w;
		@(posedge core_clk);
		#1;
		page_rx_valid = 1'h0;
		page_rx_word = ~w;
	endtask
endmodule
`default_nettype wire

/* File: verif/anab_regs_tb.sv */
// testbench of the ability registers
`timescale 1ns/1ps
`default_nettype none
module anab_regs_tb;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic pause_cfg_pin;
	logic [3:0] led_config_pins;
	anab_pkg::anab_req_t mgmt_req;
	logic [15:0] mgmt_rdata;
	logic page_rx_valid;
	logic [15:0] page_rx_word;
	logic [15:0] local_adv_word;
	logic page_rcvd;
	int mismatches = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'hA8BA;
	logic [31:0] r;
	logic [15:0] w;
	logic [15:0] d;
	always #25 core_clk = ~core_clk;
	anab_regs dut (.core_clk(core_clk), .rst_n(rst_n), .pause_cfg_pin(pause_cfg_pin),
		.led_config_pins(led_config_pins), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
		.page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word),
		.local_adv_word(local_adv_word), .page_rcvd(page_rcvd));
	anab_partner_model partner (.core_clk(core_clk), .page_rx_valid(page_rx_valid),
		.page_rx_word(page_rx_word));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [4:0] pick_sel(input logic b);
		return b ? anab_pkg::SEL_IEEE_8029 : anab_pkg::SEL_IEEE_8023;
	endfunction
	// writable local bits: 15, 13, 11..0
	function logic [15:0] exp_local(input logic [15:0] v);
		return v & 16'hAFFF;
	endfunction
	// partner bit 12 reads zero
	function logic [15:0] exp_partner(input logic [15:0] v);
		return v & 16'hEFFF;
	endfunction
	function logic [15:0] exp_reset(input logic p, input logic [3:0] t);
		return {5'h00, p, 1'h0, t, 5'h01};
	endfunction
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] v);
		mgmt_req.wr = 1'h1;
		mgmt_req.addr = a;
		mgmt_req.wdata = v;
		@(posedge core_clk);
		#1;
		mgmt_req.wr = 1'h0;
		@(posedge core_clk);
		#1;
	endtask
	task rd(input logic [4:0] a, output logic [15:0] v);
		mgmt_req.rd = 1'h1;
		mgmt_req.addr = a;
		@(posedge core_clk);
		#1;
		mgmt_req.rd = 1'h0;
		v = mgmt_rdata;
		@(posedge core_clk);
		#1;
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		mgmt_req = '0;
		r = xs();
		pause_cfg_pin = r[4];
		led_config_pins = r[3:0];
		repeat (20) @(posedge core_clk);
		#1;
		chk("in reset", local_adv_word, 16'h0001);
		rst_n = 1'h1;
		@(posedge core_clk);
		#1;
		chk("reset word", local_adv_word, exp_reset(r[4], r[3:0]));
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			r = xs();
			w = {r[15:5], pick_sel(r[0])};
			if (i == 0)
				w = 16'hFFE1;
			wr(anab_pkg::ADDR_LOCAL_ADV, w);
			chk("local word", local_adv_word, exp_local(w));
			rd(anab_pkg::ADDR_LOCAL_ADV, d);
			chk("local read", d, exp_local(w));
		end
		$display("write test done");
		for (int i = 0; i < 6; i++) begin
			r = xs();
			w = {r[15:5], pick_sel(r[1])};
			partner.send_page(w);
			chk("flag set", {15'h0000, page_rcvd}, 16'h0001);
			rd(anab_pkg::ADDR_PARTNER, d);
			chk("partner read", d, exp_partner(w));
			wr(anab_pkg::ADDR_PARTNER, ~w);
			rd(anab_pkg::ADDR_PARTNER, d);
			chk("partner kept", d, exp_partner(w));
			rd(anab_pkg::ADDR_EXPANSION, d);
			chk("flag read", d, 16'h0002);
			chk("flag clear", {15'h0000, page_rcvd}, 16'h0000);
			rd(anab_pkg::ADDR_EXPANSION, d);
			chk("flag reread", d, 16'h0000);
			// page and clearing read on one edge
			fork
				partner.send_page(w);
				rd(anab_pkg::ADDR_EXPANSION, d);
			join
			chk("set wins read", d, 16'h0000);
			chk("set wins flag", {15'h0000, page_rcvd}, 16'h0001);
		end
		rd(5'h07, d);
		chk("unmapped read", d, 16'h0000);
		$display("page test done");
		rst_n = 1'h0;
		pause_cfg_pin = ~pause_cfg_pin;
		led_config_pins = ~led_config_pins;
		repeat (4) @(posedge core_clk);
		#1;
		chk("flag in reset", {15'h0000, page_rcvd}, 16'h0000);
		chk("in reset again", local_adv_word, 16'h0001);
		rst_n = 1'h1;
		@(posedge core_clk);
		#1;
		chk("reset word again", local_adv_word, exp_reset(pause_cfg_pin, led_config_pins));
		wr(anab_pkg::ADDR_LOCAL_ADV, ~local_adv_word);
		chk("write after strap", local_adv_word, exp_local({~pause_cfg_pin, 1'h1, ~led_config_pins, 5'h1E} | 16'hF800));
		$display("second reset test done");
		end_sim();
	end
endmodule
`default_nettype wire
